// ### hw/hwmfe_top.sv
// module: hardware monitor fan count, pwm, event and index port logic
// Operation
// - fan count equals 1.35e6 over rpm times divisor
// - three-bit divisor per fan, default two
// - two independent pwm fan outputs
// - pwm duty is value over 255, default ff
// - shared pwm clock select sets pwm frequency
// - voltage limit crossings interrupt after status read
// - fan limit crossings interrupt after status read
// - sensor one comparator mode at hysteresis 127
// - uncleared comparator interrupt blocks further ones
// - sensor one two-times mode, second interrupt below hysteresis
// - sensors two three mode by property bit6
// - overtemp output uses sensors two three only
// - overtemp comparator mode holds until below hysteresis
// - overtemp latch mode cleared by temperature read
// - busy bit set by index write or serial
// - seven-bit index pointer, reset zero
// - index port then data port access order
`timescale 1ns/1ps
module hwmfe_top
  import hwmfe_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioWdata,
  output logic [7:0] ioRdata,
  input wire logic serialBusy,
  input wire logic adcValid,
  input wire logic [3:0] adcChan,
  input wire logic [7:0] adcData,
  input wire logic [1:0] fanTach,
  output logic [1:0] pwmOut,
  output logic mgmtInterruptN,
  output logic overtempOutN
);
  import hwmfe_pkg::*;

  // ==========================================================================
  // storage
  logic [7:0] ram_r [128];
  logic [6:0] idx_r;
  logic hostBusy_r;
  logic [15:0] stat_r;
  logic [1:0] seen_r;
  logic [5:0] voltViol_r;
  logic [1:0] fanViol_r;
  logic [2:0] hot_r;
  logic ovtLatch_r;
  logic [15:0] evt;
  logic [2:0] hotNxt;
  logic [1:0] seenNxt;
  logic [7:0] dataSel;
  logic idxWr, dataWr, dataRd;
  logic [1:0] pubValid;
  logic [7:0] pubVal [2];
  logic [1:0] fanViolNxt;

  function automatic logic [7:0] defVal(input logic [6:0] ix);
    case (ix)
      IX_CFG: defVal = CFG_RESET;
      IX_FANDIV: defVal = FANDIV_RESET;
      IX_PINCTL: defVal = PINCTL_RESET;
      IX_PWM1, IX_PWM2: defVal = PWM_DUTY_RESET;
      default: defVal = 8'h00;
    endcase
  endfunction

  function automatic int voltBit(input logic [2:0] ch);
    case (ch)
      3'h0: voltBit = 0;
      3'h1: voltBit = 2;
      3'h2: voltBit = 3;
      3'h3: voltBit = 8;
      3'h4: voltBit = 9;
      default: voltBit = 10;
    endcase
  endfunction

  // ==========================================================================
  // host port decode
  assign idxWr = ioWrite && (ioAddr == IDX_PORT);
  assign dataWr = ioWrite && (ioAddr == DATA_PORT);
  assign dataRd = ioRead && (ioAddr == DATA_PORT);

  always_ff @(posedge clk)
  begin
    if (srst)
      idx_r <= IDX_RESET;
    else if (idxWr)
      idx_r <= ioWdata[6:0];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      hostBusy_r <= 1'b0;
    else if (idxWr)
      hostBusy_r <= 1'b1;
    else if (dataWr || dataRd)
      hostBusy_r <= 1'b0;
  end

  always_comb
  begin
    case (idx_r)
      IX_IST1: dataSel = stat_r[7:0];
      IX_IST2: dataSel = stat_r[15:8];
      default: dataSel = ram_r[idx_r];
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      ioRdata <= 8'h00;
    else if (ioRead && ioAddr == IDX_PORT)
      ioRdata <= {hostBusy_r | serialBusy, idx_r};
    else if (dataRd)
      ioRdata <= dataSel;
    else
      ioRdata <= 8'h00;
  end

  // ==========================================================================
  // register and value ram
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 128; i++)
        ram_r[i] <= defVal(7'(i));
    end
    else
    begin
      if (dataWr)
        ram_r[idx_r] <= ioWdata;
      if (adcValid && ram_r[IX_CFG][CFG_START_BIT])
      begin
        if (adcChan < NUM_VOLT)
          ram_r[IX_VOLT0 + 7'(adcChan)] <= adcData;
        else if (adcChan == CH_TEMP1)
          ram_r[IX_TEMP1] <= adcData;
        else if (adcChan > CH_TEMP1 && adcChan <= CH_TEMP3)
          ram_r[IX_TEMP2 + 7'(adcChan - CH_TEMP1 - 4'h1)] <= adcData;
      end
      for (int f = 0; f < 2; f++)
        if (pubValid[f])
          ram_r[IX_FAN0 + 7'(f)] <= pubVal[f];
    end
  end

  // ==========================================================================
  // limit checks and event detection
  always_comb
  begin
    logic [7:0] over;
    logic [7:0] hyst;
    logic cmp;
    logic above;
    logic below;
    logic viol;
    int t;
    over = 8'h00;
    hyst = 8'h00;
    cmp = 1'b0;
    above = 1'b0;
    below = 1'b0;
    viol = 1'b0;
    t = 0;
    evt = 16'h0000;
    hotNxt = hot_r;
    fanViolNxt = fanViol_r;
    if (adcValid && ram_r[IX_CFG][CFG_START_BIT])
    begin
      if (adcChan < NUM_VOLT)
      begin
        viol = (adcData > ram_r[IX_VLIM0 + 7'({adcChan, 1'b0})])
          || (adcData < ram_r[IX_VLIM0 + 7'({adcChan, 1'b0}) + 7'h01]);
        if (viol != voltViol_r[adcChan[2:0]])
          evt[voltBit(adcChan[2:0])] = 1'b1;
      end
      else if (adcChan >= CH_TEMP1 && adcChan <= CH_TEMP3)
      begin
        t = int'(adcChan - CH_TEMP1);
        case (t)
          0:
          begin
            over = ram_r[IX_T1_OVER];
            hyst = ram_r[IX_T1_HYST];
            cmp = (hyst == T1_CMP_HYST);
          end
          1:
          begin
            over = ram_r[IX_T2_OVER];
            hyst = ram_r[IX_T2_HYST];
            cmp = ram_r[IX_INTPROP][INTPROP_CMP_BIT];
          end
          default:
          begin
            over = ram_r[IX_T3_OVER];
            hyst = ram_r[IX_T3_HYST];
            cmp = ram_r[IX_INTPROP][INTPROP_CMP_BIT];
          end
        endcase
        above = $signed(adcData) > $signed(over);
        below = $signed(adcData) < $signed(hyst);
        hotNxt[t] = above ? 1'b1 : (below ? 1'b0 : hot_r[t]);
        if (cmp)
        begin
          if (t == 0 ? above : hotNxt[t])
            evt[t == 0 ? ST_TEMP1 : (t == 1 ? ST_TEMP2 : ST_TEMP3)] = 1'b1;
        end
        else if (hotNxt[t] != hot_r[t])
          evt[t == 0 ? ST_TEMP1 : (t == 1 ? ST_TEMP2 : ST_TEMP3)] = 1'b1;
      end
    end
    for (int f = 0; f < 2; f++)
      if (pubValid[f])
      begin
        fanViolNxt[f] = pubVal[f] > ram_r[IX_FANLIM0 + 7'(f)];
        if (fanViolNxt[f] != fanViol_r[f])
          evt[ST_FAN1 + f] = 1'b1;
      end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      voltViol_r <= 6'h00;
      fanViol_r <= 2'h0;
      hot_r <= 3'h0;
    end
    else
    begin
      if (adcValid && ram_r[IX_CFG][CFG_START_BIT] && adcChan < NUM_VOLT)
        voltViol_r[adcChan[2:0]] <= (adcData > ram_r[IX_VLIM0 + 7'({adcChan, 1'b0})])
          || (adcData < ram_r[IX_VLIM0 + 7'({adcChan, 1'b0}) + 7'h01]);
      fanViol_r <= fanViolNxt;
      hot_r <= hotNxt;
    end
  end

  // ==========================================================================
  // status flags, cleared once both status registers are read
  always_comb
  begin
    seenNxt = seen_r;
    if (dataRd && idx_r == IX_IST1)
      seenNxt[0] = 1'b1;
    if (dataRd && idx_r == IX_IST2)
      seenNxt[1] = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stat_r <= 16'h0000;
      seen_r <= 2'h0;
    end
    else if (seenNxt == 2'h3)
    begin
      stat_r <= evt;
      seen_r <= 2'h0;
    end
    else
    begin
      stat_r <= stat_r | evt;
      seen_r <= seenNxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      mgmtInterruptN <= 1'b1;
    else
      mgmtInterruptN <= ~((|stat_r) && ram_r[IX_CFG][CFG_SMI_EN_BIT] && !ram_r[IX_CFG][CFG_SMI_OFF_BIT]);
  end

  // ==========================================================================
  // over-temperature output
  always_ff @(posedge clk)
  begin
    if (srst)
      ovtLatch_r <= 1'b0;
    else if (ram_r[IX_OVTCFG][OVTCFG_INT_BIT] && hotNxt[2:1] != hot_r[2:1])
      ovtLatch_r <= 1'b1;
    else if (dataRd && (idx_r == IX_TEMP2 || idx_r == IX_TEMP3))
      ovtLatch_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      overtempOutN <= 1'b1;
    else if (ram_r[IX_OVTCFG][OVTCFG_INT_BIT])
      overtempOutN <= ~ovtLatch_r;
    else
      overtempOutN <= ~(hot_r[1] | hot_r[2]);
  end

  // ==========================================================================
  // fan tachometer counting
  logic [11:0] tickCnt_r;
  logic tick_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tickCnt_r <= 12'h000;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (tickCnt_r == 12'(FAN_TICK_CYC - 1));
      tickCnt_r <= (tickCnt_r == 12'(FAN_TICK_CYC - 1)) ? 12'h000 : tickCnt_r + 12'h001;
    end
  end

  for (genvar f = 0; f < 2; f++)
  begin : gFan
    logic tachPrev_r;
    logic half_r;
    logic [7:0] divCnt_r;
    logic [7:0] cnt_r;
    logic pub_r;
    logic [7:0] val_r;
    logic [2:0] code;
    logic [7:0] divisor;
    assign code = {ram_r[IX_DIVMSB][5 + f], ram_r[IX_FANDIV][5 + 2 * f -: 2]};
    assign divisor = 8'h01 << code;
    assign pubValid[f] = pub_r;
    assign pubVal[f] = val_r;

    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        tachPrev_r <= 1'b0;
        half_r <= 1'b0;
        divCnt_r <= 8'h00;
        cnt_r <= 8'h00;
        pub_r <= 1'b0;
        val_r <= 8'h00;
      end
      else
      begin
        tachPrev_r <= fanTach[f];
        pub_r <= 1'b0;
        if (fanTach[f] && !tachPrev_r)
        begin
          half_r <= ~half_r;
          if (half_r)
          begin
            pub_r <= 1'b1;
            val_r <= cnt_r;
            cnt_r <= 8'h00;
            divCnt_r <= 8'h00;
          end
        end
        else if (tick_r)
        begin
          if (divCnt_r >= divisor - 8'h01)
          begin
            divCnt_r <= 8'h00;
            if (cnt_r == CNT_MAX)
            begin
              pub_r <= 1'b1;
              val_r <= CNT_MAX;
              cnt_r <= 8'h00;
              half_r <= 1'b0;
            end
            else
              cnt_r <= cnt_r + 8'h01;
          end
          else
            divCnt_r <= divCnt_r + 8'h01;
        end
      end
    end
  end

  // ==========================================================================
  // pwm generation
  logic [7:0] preCnt_r;
  logic [7:0] step_r;
  logic [7:0] preTop;
  assign preTop = (8'h01 << ram_r[IX_PWMCLK][2:0]) - 8'h01;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      preCnt_r <= 8'h00;
      step_r <= 8'h00;
    end
    else if (preCnt_r >= preTop)
    begin
      preCnt_r <= 8'h00;
      step_r <= (step_r >= PWM_TOP) ? 8'h00 : step_r + 8'h01;
    end
    else
      preCnt_r <= preCnt_r + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      pwmOut <= 2'h3;
    else
      pwmOut <= {step_r < ram_r[IX_PWM2], step_r < ram_r[IX_PWM1]};
  end
endmodule // hwmfe_top

// ### hw/hwmfe_pkg.sv
// package: constants for the hardware monitor fan and event logic
package hwmfe_pkg;
  // ==========================================================================
  // host port map
  localparam logic [15:0] IO_BASE = 16'h0290;
  localparam logic [15:0] ADDR_REG_OFS = 16'h0005;
  localparam logic [15:0] DATA_REG_OFS = 16'h0006;
  localparam logic [15:0] IDX_PORT = IO_BASE + ADDR_REG_OFS;
  localparam logic [15:0] DATA_PORT = IO_BASE + DATA_REG_OFS;
  localparam logic [6:0] IDX_RESET = 7'h00;
  // ==========================================================================
  // internal indexes
  localparam logic [6:0] IX_VOLT0 = 7'h20;
  localparam logic [6:0] IX_TEMP1 = 7'h27;
  localparam logic [6:0] IX_FAN0 = 7'h28;
  localparam logic [6:0] IX_VLIM0 = 7'h2b;
  localparam logic [6:0] IX_T1_OVER = 7'h39;
  localparam logic [6:0] IX_T1_HYST = 7'h3a;
  localparam logic [6:0] IX_FANLIM0 = 7'h3b;
  localparam logic [6:0] IX_CFG = 7'h40;
  localparam logic [6:0] IX_IST1 = 7'h41;
  localparam logic [6:0] IX_IST2 = 7'h42;
  localparam logic [6:0] IX_FANDIV = 7'h47;
  localparam logic [6:0] IX_PINCTL = 7'h4b;
  localparam logic [6:0] IX_INTPROP = 7'h4c;
  localparam logic [6:0] IX_TEMP2 = 7'h50;
  localparam logic [6:0] IX_TEMP3 = 7'h51;
  localparam logic [6:0] IX_OVTCFG = 7'h52;
  localparam logic [6:0] IX_T2_OVER = 7'h53;
  localparam logic [6:0] IX_T2_HYST = 7'h54;
  localparam logic [6:0] IX_T3_OVER = 7'h55;
  localparam logic [6:0] IX_T3_HYST = 7'h56;
  localparam logic [6:0] IX_PWM1 = 7'h5a;
  localparam logic [6:0] IX_PWM2 = 7'h5b;
  localparam logic [6:0] IX_PWMCLK = 7'h5c;
  localparam logic [6:0] IX_DIVMSB = 7'h5d;
  // ==========================================================================
  // reset values and fields
  localparam logic [7:0] CFG_RESET = 8'h01;
  localparam logic [7:0] FANDIV_RESET = 8'h50;
  localparam logic [7:0] PINCTL_RESET = 8'h44;
  localparam logic [7:0] PWM_DUTY_RESET = 8'hff;
  localparam int CFG_START_BIT = 0;
  localparam int CFG_SMI_EN_BIT = 1;
  localparam int CFG_SMI_OFF_BIT = 3;
  localparam int INTPROP_CMP_BIT = 6;
  localparam int OVTCFG_INT_BIT = 2;
  localparam logic [7:0] T1_CMP_HYST = 8'h7f;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] PWM_TOP = 8'hfe;
  // ==========================================================================
  // conversion channels and status bit positions ({status2, status1})
  localparam logic [3:0] NUM_VOLT = 4'h6;
  localparam logic [3:0] CH_TEMP1 = 4'h8;
  localparam logic [3:0] CH_TEMP3 = 4'ha;
  localparam int ST_TEMP1 = 4;
  localparam int ST_TEMP2 = 5;
  localparam int ST_FAN1 = 6;
  localparam int ST_TEMP3 = 11;
  // ==========================================================================
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int FAN_BASE_HZ = 22_500;
  localparam int FAN_TICK_CYC = CLK_HZ / FAN_BASE_HZ;
endpackage

// ### dv/hwmfe_top_sva.sv
// checker: port assertions for the monitor top
`timescale 1ns/1ps
module hwmfe_top_sva
  import hwmfe_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioWdata,
  input wire logic [7:0] ioRdata,
  input wire logic serialBusy,
  input wire logic adcValid,
  input wire logic [3:0] adcChan,
  input wire logic [1:0] pwmOut,
  input wire logic mgmtInterruptN,
  input wire logic overtempOutN
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ==========
  // host port steps
  sequence idxWr; ioWrite && ioAddr == IDX_PORT; endsequence
  sequence idxRd; ioRead && ioAddr == IDX_PORT; endsequence
  sequence datRd; ioRead && ioAddr == DATA_PORT; endsequence
  // conversions of sensors two and three, delayed
  logic [2:0] hotSrc_r;
  always_ff @(posedge clk)
  begin
    hotSrc_r <= srst ? 3'h0 : {hotSrc_r[1:0], adcValid && (adcChan == 4'h9 || adcChan == 4'ha)};
  end
  // ==========
  // assertions
  a_rdata_quiet: assert property (
    !(ioRead && (ioAddr == IDX_PORT || ioAddr == DATA_PORT)) |=> ioRdata == 8'h00)
    else $error("read data without a read");
  a_busy_index: assert property (idxWr ##1 idxRd |=> ioRdata[7])
    else $error("busy not set by index write");
  a_index_back: assert property (
    idxWr ##1 idxRd |=> ioRdata[6:0] == $past(ioWdata[6:0], 2))
    else $error("index pointer lost");
  a_busy_serial: assert property (serialBusy[*3] ##0 idxRd |=> ioRdata[7])
    else $error("busy not set by serial bus");
  a_busy_clear: assert property (
    !serialBusy throughout (idxWr ##1 datRd ##2 idxRd) |=> !ioRdata[7])
    else $error("busy not cleared by data access");
  a_pwm_reset: assert property ($fell(srst) |-> pwmOut == 2'h3)
    else $error("pwm not full after reset");
  a_alarm_reset: assert property ($fell(srst) |-> mgmtInterruptN && overtempOutN)
    else $error("alarm active after reset");
  a_ovt_source: assert property ($fell(overtempOutN) |-> |hotSrc_r[2:1])
    else $error("overtemp without sensor two or three");
endmodule // hwmfe_top_sva
bind hwmfe_top hwmfe_top_sva chk (.clk(clk), .srst(srst), .ioAddr(ioAddr), .ioWrite(ioWrite),
  .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata), .serialBusy(serialBusy), .adcValid(adcValid),
  .adcChan(adcChan), .pwmOut(pwmOut), .mgmtInterruptN(mgmtInterruptN), .overtempOutN(overtempOutN));

// ### dv/hwmfe_serial_model.sv
// model: serial-bus master that holds the monitor busy
`timescale 1ns/1ps
module hwmfe_serial_model
(
  input wire logic clk,
  input wire logic start,
  output logic serialBusy
);
  logic [3:0] left_r = 4'h0;
  // one ten-clock transaction, started by any start pulse whatever the host is doing
  always_ff @(posedge clk)
  begin
    if (start)
      left_r <= 4'ha;
    else if (left_r != 4'h0)
      left_r <= left_r - 4'h1;
  end
  assign serialBusy = (left_r != 4'h0);
endmodule // hwmfe_serial_model

// ### dv/hwmfe_top_test.sv
// testbench: register, alarm and pwm tests for the monitor top
`timescale 1ns/1ps
module hwmfe_top_test;
  import hwmfe_pkg::*;
  logic clk, srst, ioWrite, ioRead, adcValid, serGo, serialBusy, mgmtInterruptN, overtempOutN;
  logic [15:0] ioAddr;
  logic [7:0] ioWdata, ioRdata, adcData, v;
  logic [3:0] adcChan;
  logic [1:0] pwmOut, fanTach;
  int badCount = 0;
  int checked = 0;
  hwmfe_top dut (.clk(clk), .srst(srst), .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead),
    .ioWdata(ioWdata), .ioRdata(ioRdata), .serialBusy(serialBusy), .adcValid(adcValid), .adcChan(adcChan),
    .adcData(adcData), .fanTach(fanTach), .pwmOut(pwmOut), .mgmtInterruptN(mgmtInterruptN),
    .overtempOutN(overtempOutN));
  hwmfe_serial_model ser (.clk(clk), .start(serGo), .serialBusy(serialBusy));
  // ==========
  // tasks
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    ioWrite <= w;
    ioRead <= !w;
    ioAddr <= a;
    ioWdata <= d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a);
    io(1'b0, a, 8'h00);
    ioRead <= 1'b0;
    @(negedge clk);
    v = ioRdata;
    @(posedge clk);
  endtask
  task automatic wr(input logic [6:0] ix, input logic [7:0] d);
    io(1'b1, IDX_PORT, {1'b0, ix});
    io(1'b1, DATA_PORT, d);
  endtask
  task automatic chk(input string n, input logic [6:0] ix, input logic [7:0] e);
    io(1'b1, IDX_PORT, {1'b0, ix});
    rd(DATA_PORT);
    cmp(n, {8'h00, e}, {8'h00, v});
  endtask
  task automatic adc(input logic [3:0] ch, input logic [7:0] d);
    ioWrite <= 1'b0;
    adcValid <= 1'b1;
    adcChan <= ch;
    adcData <= d;
    @(posedge clk);
    adcValid <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task automatic tach(input int n);
    fanTach <= 2'h1;
    @(posedge clk);
    fanTach <= 2'h0;
    repeat (n) @(posedge clk);
  endtask
  task automatic pin(input logic sel, input logic e);
    @(posedge clk);
    @(negedge clk);
    cmp(sel ? "overtemp" : "alarm", {15'h0000, e}, {15'h0000, sel ? overtempOutN : mgmtInterruptN});
    @(posedge clk);
  endtask
  task automatic pwm(input logic [15:0] n, input logic [15:0] e0, input logic [15:0] e1);
    logic [15:0] h0, h1;
    h0 = 16'h0000;
    h1 = 16'h0000;
    ioWrite <= 1'b0;
    repeat (8) @(posedge clk);
    repeat (n)
    begin
      @(negedge clk);
      h0 += pwmOut[0];
      h1 += pwmOut[1];
      @(posedge clk);
    end
    cmp("pwm1 high", e0, h0);
    cmp("pwm2 high", e1, h1);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========
  // clock, watchdog, tests
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (32'h00008000) @(posedge clk);
    badCount++;
    end_sim;
  end
  initial
  begin
    srst = 1'b1;
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioAddr = 16'h0000;
    ioWdata = 8'h00;
    adcValid = 1'b0;
    adcChan = 4'h0;
    adcData = 8'h00;
    serGo = 1'b0;
    fanTach = 2'h0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(IDX_PORT);
    cmp("index", 16'h0000, {8'h00, v});
    chk("fan div", IX_FANDIV, 8'h50);
    chk("duty1", IX_PWM1, 8'hff);
    chk("duty2", IX_PWM2, 8'hff);
    io(1'b1, IDX_PORT, 8'h7f);
    rd(DATA_PORT);
    rd(IDX_PORT);
    cmp("index idle", 16'h007f, {8'h00, v});
    io(1'b1, IDX_PORT, 8'h3c);
    rd(IDX_PORT);
    cmp("index busy", 16'h00bc, {8'h00, v});
    rd(DATA_PORT);
    serGo <= 1'b1;
    @(posedge clk);
    serGo <= 1'b0;
    repeat (3) @(posedge clk);
    rd(IDX_PORT);
    cmp("serial busy", 16'h00bc, {8'h00, v});
    repeat (12) @(posedge clk);
    rd(IDX_PORT);
    cmp("serial done", 16'h003c, {8'h00, v});
    pwm(16'h00ff, 16'h00ff, 16'h00ff);
    wr(IX_PWM1, 8'h80);
    pwm(16'h00ff, 16'h0080, 16'h00ff);
    wr(IX_PWMCLK, 8'h01);
    pwm(16'h01fe, 16'h0100, 16'h01fe);
    wr(IX_CFG, 8'h03);
    wr(IX_VLIM0, 8'h80);
    wr(IX_VLIM0 + 7'h01, 8'h10);
    adc(4'h0, 8'h90);
    pin(1'b0, 1'b0);
    chk("status1", IX_IST1, 8'h01);
    chk("status2", IX_IST2, 8'h00);
    adc(4'h0, 8'h95);
    pin(1'b0, 1'b1);
    adc(4'h0, 8'h50);
    pin(1'b0, 1'b0);
    chk("status1", IX_IST1, 8'h01);
    chk("status2", IX_IST2, 8'h00);
    wr(IX_T1_HYST, 8'h7f);
    wr(IX_T1_OVER, 8'h50);
    adc(4'h8, 8'h60);
    adc(4'h8, 8'h60);
    chk("status1", IX_IST1, 8'h10);
    chk("status2", IX_IST2, 8'h00);
    pin(1'b0, 1'b1);
    adc(4'h8, 8'h60);
    pin(1'b0, 1'b0);
    chk("status1", IX_IST1, 8'h10);
    chk("status2", IX_IST2, 8'h00);
    adc(4'h8, 8'h30);
    pin(1'b0, 1'b1);
    wr(IX_T2_OVER, 8'h50);
    wr(IX_T2_HYST, 8'h40);
    adc(4'h9, 8'h60);
    pin(1'b1, 1'b0);
    adc(4'h9, 8'h45);
    pin(1'b1, 1'b0);
    adc(4'h9, 8'h30);
    pin(1'b1, 1'b1);
    adc(4'h8, 8'h60);
    pin(1'b1, 1'b1);
    wr(IX_OVTCFG, 8'h04);
    adc(4'h9, 8'h60);
    adc(4'h9, 8'h45);
    pin(1'b1, 1'b0);
    chk("temp2", IX_TEMP2, 8'h45);
    pin(1'b1, 1'b1);
    adc(4'h9, 8'h55);
    pin(1'b1, 1'b1);
    adc(4'h9, 8'h30);
    pin(1'b1, 1'b0);
    // fan one, divisor one: two quick rising edges, then a measured pair three tick periods apart, well away from a tick
    wr(IX_FANDIV, 8'h00);
    @(posedge clk iff dut.tick_r);
    repeat (1100) @(posedge clk);
    tach(1);
    tach(1);
    tach(3 * FAN_TICK_CYC - 3);
    tach(4);
    chk("fan1 count", IX_FAN0, 8'h03);
    chk("status1", IX_IST1, 8'h70);
    chk("status2", IX_IST2, 8'h00);
    end_sim;
  end
endmodule // hwmfe_top_test
